// ---- rtl/rtss_pkg.sv ----
// Package: constants and types for the reset and test strap sampler
package rtss_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int unsigned TEST_POINT_COUNT = 8;   // Number of test-point pins

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ      = 40000000;   // Core clock rate
    localparam int unsigned STRAP_DELAY_NS   = 1500;       // Strap sample delay, 1.5 us
    // Cycles from synchronised release to sample (nominal figure, rounded down)
    localparam int unsigned STRAP_DELAY_CYC  =
        (STRAP_DELAY_NS * (CLK_FREQ_HZ / 1000000)) / 1000 < 1 ? 1 :
        (STRAP_DELAY_NS * (CLK_FREQ_HZ / 1000000)) / 1000;
    localparam int unsigned STRAP_CNT_W      = 8;          // Width of the delay counter

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [TEST_POINT_COUNT-1:0] TEST_MODE_NORMAL = 8'h00;   // Pulled-down default
    localparam logic [TEST_POINT_COUNT-1:0] TEST_OUT_RESET   = 8'h00;   // Idle test output value

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        RTSS_HELD,      // Power-on reset asserted
        RTSS_WAIT,      // Counting down to the strap sample
        RTSS_RUN        // Strap taken, pins driven, configuring
    } rtss_state_t;

    // Two-signal view of the test-point pins
    typedef struct packed
    {
        logic [TEST_POINT_COUNT-1:0] out;   // Value driven onto the pins
        logic [TEST_POINT_COUNT-1:0] oe;    // High while the block drives
    } rtss_pin_drive_t;

endpackage

// ---- rtl/rtss_reset_strap.sv ----
// Module: power-on reset release, test strap sampling and test-pin drive
`timescale 1ns/100ps
// How it works
// - Outputs other than the pulldown enables stay inactive while reset held low
// - Rising reset edge starts self-configuration
// - All eight test pins tri-stated during reset
// - Sample pins 1.5 us after release, then drive
// - Weak pulldowns make normal mode the default
// - Pins only reserved test outputs in normal use
module rtss_reset_strap #(
    parameter int unsigned STRAP_DELAY_CYC = rtss_pkg::STRAP_DELAY_CYC
) (
    // Core clock and reset
    input  wire logic                                   clk,
    input  wire logic                                   rst,
    // Power-on reset pin, asynchronous to clk
    input  wire logic                                   power_on_reset_n,
    // Test-point pins, split into four signals
    input  wire logic [rtss_pkg::TEST_POINT_COUNT-1:0]  test_point_pin_in,
    output logic      [rtss_pkg::TEST_POINT_COUNT-1:0]  test_point_pin_out,
    output logic      [rtss_pkg::TEST_POINT_COUNT-1:0]  test_point_pin_oe,
    output logic      [rtss_pkg::TEST_POINT_COUNT-1:0]  test_point_pin_pd_en,
    // Test-port reset pin, only observed
    input  wire logic                                   test_port_reset_n,
    // Test values from the core for driving after the strap
    input  wire logic [rtss_pkg::TEST_POINT_COUNT-1:0]  test_out_value,
    // Results to the rest of the device
    output logic                                        core_reset_n,
    output logic                                        config_start,
    output logic                                        config_active,
    output logic [rtss_pkg::TEST_POINT_COUNT-1:0]       test_mode,
    output logic                                        test_mode_valid,
    output logic                                        test_port_reset_seen
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic                               por_meta;       // First sync stage, read by por_sync only
    logic                               por_sync;       // Synchronised reset level
    logic                               por_prev;       // Previous synchronised level
    logic [rtss_pkg::TEST_POINT_COUNT-1:0] tp_meta;     // First sync stage of the pins
    logic [rtss_pkg::TEST_POINT_COUNT-1:0] tp_sync;     // Synchronised pin levels
    logic                               trst_meta;      // First sync stage of test-port reset
    logic                               trst_sync;      // Synchronised test-port reset
    logic [rtss_pkg::STRAP_CNT_W-1:0]   strap_cnt;      // Delay counter to the sample
    rtss_pkg::rtss_state_t              state;          // Sequencer state
    rtss_pkg::rtss_state_t              next_state;     // Next sequencer state
    rtss_pkg::rtss_pin_drive_t          pin_drive;      // Registered pin drive
    logic                               release_edge;   // Low-to-high on synced reset
    logic                               sample_now;     // Strap sample instant

    localparam logic [rtss_pkg::STRAP_CNT_W-1:0] DELAY_LAST =
        rtss_pkg::STRAP_CNT_W'(STRAP_DELAY_CYC - 1);    // Terminal count

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------

    // Two stages on the reset pin; a low takes two cycles to reach por_sync, like a high
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            por_meta <= 1'b0;
            por_sync <= 1'b0;
        end
        else
        begin
            por_meta <= power_on_reset_n;
            por_sync <= por_meta;
        end
    end

    // Edge detector reads only the second stage
    always_ff @(posedge clk)
    begin
        if (rst)
            por_prev <= 1'b0;
        else
            por_prev <= por_sync;
    end

    // Pins cross into clk before the sample reads them
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tp_meta <= rtss_pkg::TEST_MODE_NORMAL;
            tp_sync <= rtss_pkg::TEST_MODE_NORMAL;
        end
        else
        begin
            tp_meta <= test_point_pin_in;
            tp_sync <= tp_meta;
        end
    end

    // Test-port reset observed only, so a stuck-high board shows up
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            trst_meta <= 1'b0;
            trst_sync <= 1'b0;
        end
        else
        begin
            trst_meta <= test_port_reset_n;
            trst_sync <= trst_meta;
        end
    end

    assign release_edge = por_sync && !por_prev;
    assign sample_now   = (state == rtss_pkg::RTSS_WAIT) && (strap_cnt == DELAY_LAST);

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------

    // Next state; any low reset level returns to held
    always_comb
    begin
        next_state = state;
        case (state)
            rtss_pkg::RTSS_HELD:
            begin
                if (release_edge)
                    next_state = rtss_pkg::RTSS_WAIT;
            end
            rtss_pkg::RTSS_WAIT:
            begin
                if (!por_sync)
                    next_state = rtss_pkg::RTSS_HELD;
                else if (sample_now)
                    next_state = rtss_pkg::RTSS_RUN;
            end
            rtss_pkg::RTSS_RUN:
            begin
                if (!por_sync)
                    next_state = rtss_pkg::RTSS_HELD;
            end
            default:
                next_state = rtss_pkg::RTSS_HELD;
        endcase
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
            state <= rtss_pkg::RTSS_HELD;
        else
            state <= next_state;
    end

    // Delay counter, cleared outside the wait so each release times afresh
    always_ff @(posedge clk)
    begin
        if (rst || state != rtss_pkg::RTSS_WAIT)
            strap_cnt <= '0;
        else
            strap_cnt <= strap_cnt + 1'b1;
    end

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------

    // Taken once per release; pulldowns make all-zero the normal mode
    always_ff @(posedge clk)
    begin
        if (rst || state == rtss_pkg::RTSS_HELD)
        begin
            test_mode       <= rtss_pkg::TEST_MODE_NORMAL;
            test_mode_valid <= 1'b0;
        end
        else if (sample_now && por_sync)
        begin
            test_mode       <= tp_sync;
            test_mode_valid <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------

    // Tri-state until sampled, then drive as reserved test outputs
    always_ff @(posedge clk)
    begin
        if (rst || next_state != rtss_pkg::RTSS_RUN)
        begin
            pin_drive.out <= rtss_pkg::TEST_OUT_RESET;
            pin_drive.oe  <= '0;
        end
        else
        begin
            pin_drive.out <= test_out_value;
            pin_drive.oe  <= '1;
        end
    end

    assign test_point_pin_out   = pin_drive.out;
    assign test_point_pin_oe    = pin_drive.oe;
    assign test_point_pin_pd_en = '1;

    // ----------------------------------------------------------------
    // Device-wide status
    // ----------------------------------------------------------------

    // Start pulse and active level follow the sample; all low in reset
    always_ff @(posedge clk)
    begin
        if (rst || !por_sync)
        begin
            core_reset_n  <= 1'b0;
            config_start  <= 1'b0;
            config_active <= 1'b0;
        end
        else
        begin
            core_reset_n  <= 1'b1;
            config_start  <= sample_now;
            config_active <= config_active || sample_now;
        end
    end

    // Flag a high test-port reset seen while the synchronised reset is high (board fault)
    always_ff @(posedge clk)
    begin
        if (rst)
            test_port_reset_seen <= 1'b0;
        else
            test_port_reset_seen <= trst_sync && por_sync;
    end

endmodule

// ---- bench/rtss_reset_strap_sva.sv ----
// Checker: reset, strap timing and pin-state assertions
`timescale 1ns/100ps
module rtss_reset_strap_sva #(
    parameter int unsigned STRAP_DELAY_CYC = 60
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Pins
    input wire logic       power_on_reset_n,
    input wire logic [7:0] test_point_pin_in,
    input wire logic [7:0] test_point_pin_out,
    input wire logic [7:0] test_point_pin_oe,
    input wire logic [7:0] test_point_pin_pd_en,
    input wire logic [7:0] test_out_value,
    // Results
    input wire logic       core_reset_n,
    input wire logic       config_start,
    input wire logic       config_active,
    input wire logic [7:0] test_mode,
    input wire logic       test_mode_valid,
    input wire logic       test_port_reset_seen
);
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    localparam int LO = STRAP_DELAY_CYC + 3;   // Earliest legal sample, the nominal cycle with no slack
    localparam int HI = STRAP_DELAY_CYC + 5;   // Latest legal sample
    logic [7:0] up;                            // Cycles the reset pin has been high
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Saturating count, so a long run never wraps into the window
    always_ff @(posedge clk)
    begin
        if (rst || !power_on_reset_n)
            up <= 8'h00;
        else if (up != 8'hFF)
            up <= up + 8'h01;
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_held_inactive: assert property (!power_on_reset_n [*5] |->
        !core_reset_n && !config_start && !config_active && !test_mode_valid && test_mode == 8'h00 &&
        !test_port_reset_seen && test_point_pin_out == 8'h00)
        else $error("status active while reset held");
    a_held_tristate: assert property (!power_on_reset_n [*5] |-> test_point_pin_oe == 8'h00)
        else $error("test pins driven while reset held");
    a_sample_time: assert property (config_start |-> up >= LO && up <= HI)
        else $error("strap sampled at wrong time");
    a_start_pulse: assert property (config_start |=> !config_start)
        else $error("start pulse too long");
    a_start_state: assert property (config_start |-> config_active && test_point_pin_oe == 8'hFF)
        else $error("start without drive");
    a_mode_capture: assert property (config_start |-> test_mode == $past(test_point_pin_in, 3))
        else $error("wrong strap captured");
    a_mode_hold: assert property (test_mode_valid && $past(test_mode_valid) |-> $stable(test_mode))
        else $error("strap value moved");
    a_drive_follow: assert property (test_point_pin_oe[0] && $past(test_point_pin_oe[0]) |->
        test_point_pin_out == $past(test_out_value))
        else $error("pin drive not following core");
    a_pull_down: assert property (test_point_pin_pd_en == 8'hFF)
        else $error("pulldown not enabled");
    // Main scenarios reached
    c_start: cover property (config_start);
    c_test_mode: cover property (test_mode_valid && test_mode != 8'h00);
    c_port_reset: cover property (test_port_reset_seen);
endmodule
bind rtss_reset_strap rtss_reset_strap_sva #(.STRAP_DELAY_CYC(STRAP_DELAY_CYC)) rtss_reset_strap_sva_inst (
    .clk(clk), .rst(rst), .power_on_reset_n(power_on_reset_n), .test_point_pin_in(test_point_pin_in),
    .test_point_pin_out(test_point_pin_out), .test_point_pin_oe(test_point_pin_oe),
    .test_point_pin_pd_en(test_point_pin_pd_en), .test_out_value(test_out_value),
    .core_reset_n(core_reset_n), .config_start(config_start), .config_active(config_active),
    .test_mode(test_mode), .test_mode_valid(test_mode_valid), .test_port_reset_seen(test_port_reset_seen));

// ---- bench/rtss_pmic_model.sv ----
// Partner model: power controller on the reset line, and test-pin wiring
`timescale 1ns/100ps
module rtss_pmic_model (
    // Clock and bench requests
    input  wire logic       clk,
    input  wire logic       release_req,
    input  wire logic       test_reset_req,
    input  wire logic [7:0] strap,
    // Drive from the block
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    // Lines to the block
    output logic            power_on_reset_n,
    output logic            test_port_reset_n,
    output logic [7:0]      pin_in
);
    logic [3:0] run_cnt = 4'h0;   // Clock cycles seen since power-up
    // Clock settling counter
    always @(posedge clk)
        if (run_cnt != 4'hF)
            run_cnt <= run_cnt + 4'h1;
    // Release held back until the clock has run a while
    assign power_on_reset_n  = release_req && (run_cnt >= 4'h8);
    // Test-port reset stays low unless a scenario asks
    assign test_port_reset_n = test_reset_req;
    // Strap removed once the block drives; else pull-up or pulldown
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & strap);
endmodule

// ---- bench/reset_and_test_strap_sampler_bench.sv ----
// Testbench: random and corner-case reset releases with strap checks
`timescale 1ns/100ps
module reset_and_test_strap_sampler_bench;
    localparam int unsigned DLY = 16;   // Shortened strap delay
    logic       clk = 1'b0;             // Core clock
    logic       rst = 1'b1;             // Sync reset
    logic       rel = 1'b0;             // Release request
    logic       trq = 1'b0;             // Test-port reset request
    logic [7:0] strap = 8'h00;          // External strap levels
    logic [7:0] tov = 8'h00;            // Core test values
    logic [15:0] lfsr = 16'hA50B;       // Random state
    logic       por_n, tpr_n, cst, cact, crn, mval, seen;
    logic [7:0] pin_in, pin_out, pin_oe, mode, pd;
    int         fail_count = 0;
    int         tests_run = 0;
    always #12.5 clk = ~clk;
    rtss_pmic_model rtss_pmic_model_inst (.clk(clk), .release_req(rel), .test_reset_req(trq),
        .strap(strap), .pin_out(pin_out), .pin_oe(pin_oe), .power_on_reset_n(por_n),
        .test_port_reset_n(tpr_n), .pin_in(pin_in));
    rtss_reset_strap #(.STRAP_DELAY_CYC(DLY)) rtss_reset_strap_inst (.clk(clk), .rst(rst),
        .power_on_reset_n(por_n), .test_point_pin_in(pin_in), .test_point_pin_out(pin_out),
        .test_point_pin_oe(pin_oe), .test_point_pin_pd_en(pd), .test_port_reset_n(tpr_n),
        .test_out_value(tov), .core_reset_n(crn), .config_start(cst), .config_active(cact),
        .test_mode(mode), .test_mode_valid(mval), .test_port_reset_seen(seen));
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Fresh random core value every cycle
    always @(posedge clk)
    begin
        lfsr <= lfsr_next(lfsr);
        tov  <= lfsr[7:0];
    end
    task automatic check(input logic [7:0] seen_v, input logic [7:0] exp_v);
        tests_run++;
        if (seen_v !== exp_v)
        begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen_v, exp_v);
        end
    endtask
    task automatic complete_run;
        if (fail_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // One release with strap s, then reset dropped again
    task automatic run_cycle(input logic [7:0] s);
        int n;
        logic [7:0] drv;
        n = 0;
        @(posedge clk);
        strap <= s;
        @(posedge clk);
        rel <= 1'b1;
        while (cst !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check({7'h00, n >= DLY + 3 && n <= DLY + 5}, 8'h01);
        check(mode, s);
        check(pin_oe, 8'hFF);
        check({6'h00, crn, cact}, 8'h03);
        drv = tov;
        @(posedge clk);
        #1;
        check({7'h00, cst}, 8'h00);
        check(pin_out, drv);
        check({7'h00, seen}, {7'h00, trq});
        @(posedge clk);
        rel <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        check({4'h0, crn, cact, mval, cst}, 8'h00);
        check(pin_oe | mode, 8'h00);
        check(pd, 8'hFF);
    endtask
    // Hang guard
    initial
    begin
        #100000;
        fail_count++;
        complete_run();
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (12) @(posedge clk);
        // Pulldown default, all high, single-bit ends, then random
        run_cycle(8'h00);
        run_cycle(8'hFF);
        run_cycle(8'h01);
        run_cycle(8'h80);
        repeat (6) run_cycle(lfsr[15:8]);
        // Release withdrawn in mid count: no sample may follow
        @(posedge clk);
        rel <= 1'b1;
        repeat (6) @(posedge clk);
        rel <= 1'b0;
        repeat (DLY + 8)
        begin
            @(posedge clk);
            #1;
            check({6'h00, cact, mval}, 8'h00);
        end
        // Core reset pulsed while running: all cleared, then a full restart
        @(posedge clk);
        strap <= 8'hC3;
        rel <= 1'b1;
        repeat (DLY + 8) @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        #1;
        check({4'h0, crn, cact, mval, cst}, 8'h00);
        check(pin_oe | mode, 8'h00);
        @(posedge clk);
        rst <= 1'b0;
        repeat (DLY + 3) @(posedge clk);
        #1;
        check({7'h00, cst}, 8'h01);
        check(mode, 8'hC3);
        @(posedge clk);
        rel <= 1'b0;
        repeat (5) @(posedge clk);
        // Test-port reset seen high while running
        trq <= 1'b1;
        run_cycle(8'h5A);
        @(posedge clk);
        trq <= 1'b0;
        complete_run();
    end
endmodule
